// ==== design/sisr_alloc.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sisr_consts.svh"

module sisr_alloc (
	input  wire sisr_pkg::sisr_pins_t pins_i,
	input  wire sisr_pkg::sisr_code_t code_i,
	input  wire logic                 user_mode_i,
	input  wire logic [2:0]           fixed_pin_i,
	output logic                      active_o
);
	import sisr_pkg::*;

	wire       is_on   = (code_i == `SISR_CODE_ON);
	wire       is_off  = (code_i == `SISR_CODE_OFF);
	wire       is_low  = (code_i < `SISR_CODE_ON);
	wire [3:0] hi_diff = code_i - `SISR_CODE_HI_BASE;
	wire [2:0] hi_idx  = hi_diff[2:0];
	wire [2:0] lo_idx  = code_i[2:0];

	wire fixed_lvl = ~pins_i[fixed_pin_i];
	wire user_lvl  = is_low ? ~pins_i[lo_idx] : pins_i[hi_idx];

	// Forced codes win in either allocation mode
	assign active_o = is_on  ? 1'b1 :            // [RL15] [RL18] [RL19]
	                  is_off ? 1'b0 :            // [RL15] [RL18] [RL19]
	                  user_mode_i ? user_lvl :   // [RL16] [RL18]
	                  fixed_lvl;                 // [RL19]

endmodule : sisr_alloc

`default_nettype wire

// ==== design/sisr_router.sv ====
// How it works
// [RL1] Fixed allocation: run comes from first line
// [RL2] Line two is gain reduction in modes 0,1
// [RL3] Modes 3-5, no speed select: gain reduction
// [RL4] Modes 3-6, speed select active: rotation direction
// [RL5] Modes 7-9: line two switches control mode
// [RL6] Mode A: line two is position lock
// [RL7] Mode b: line two inhibits command pulses
// [RL8] Drive prohibit forced inactive by default
// [RL9] Fixed allocation: alarm reset from fifth line
// [RL10] Line six: forward limit, or speed select 1
// [RL11] Line seven: reverse limit, or speed select 2
// [RL12] Pair one: positioning done or speed match
// [RL13] Pair two rotating, pair three servo ready
// [RL14] Allocation mode: 0 fixed, 1 user, default 0
// [RL15] Fixed mode: pins locked, forcing still allowed
// [RL16] User mode: one pin may drive many functions
// [RL17] Run allocation is four bits, default 0
// [RL18] Codes 0-6 low, 9-F high, 7 on, 8 off
// [RL19] Fixed mode uses default pin, active low
// [RL20] Settings take effect only at restart
// [RL21] Input lines pass two synchronising flip-flops
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sisr_consts.svh"

module sisr_router (
	input  wire logic                 core_clk_i,
	input  wire logic                 reset_i,
	// Register port
	input  wire sisr_pkg::sisr_addr_t addr_i,
	input  wire sisr_pkg::sisr_word_t wr_data_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output sisr_pkg::sisr_word_t      rd_data_o,
	// Connector input lines
	input  wire sisr_pkg::sisr_pins_t io_connector_i,
	// Status from the servo core
	input  wire logic                 positioning_done_i,
	input  wire logic                 speed_match_i,
	input  wire logic                 motor_rotating_i,
	input  wire logic                 servo_ready_i,
	// Routed sequence functions
	output logic                      run_o,
	output logic                      gain_reduce_in_o,
	output logic                      rotation_dir_in_o,
	output logic                      ctrl_mode_switch_in_o,
	output logic                      position_lock_in_o,
	output logic                      pulse_inhibit_in_o,
	output logic                      fwd_prohibit_in_o,
	output logic                      rev_prohibit_o,
	output logic                      alarm_reset_o,
	output logic                      fwd_current_limit_in_o,
	output logic                      rev_current_limit_in_o,
	output logic                      speed_sel_a_in_o,
	output logic                      speed_sel_b_in_o,
	// Output pin pairs
	output logic                      out_pair1_o,
	output logic                      out_pair2_o,
	output logic                      out_pair3_o
);
	import sisr_pkg::*;

	// Staged settings written by software
	logic       alloc_mode_stg_q;
	sisr_code_t ctrl_mode_stg_q;
	sisr_word_t alloc_stg_q;

	// Settings in force since the last restart
	logic       allocation_mode_q;
	sisr_code_t control_mode_select_q;
	sisr_word_t alloc_act_q;

	logic       restart_q;
	sisr_word_t rd_data_q;

	// Bus decode
	// Exact decode, so no alias can reach the restart strobe
	wire hit_config  = (addr_i == `SISR_OFS_CONFIG);
	wire hit_alloc   = (addr_i == `SISR_OFS_ALLOC);
	wire hit_restart = (addr_i == `SISR_OFS_RESTART);
	wire hit_func    = (addr_i == `SISR_OFS_FUNC);
	wire hit_pins    = (addr_i == `SISR_OFS_PINS);
	wire hit_active  = (addr_i == `SISR_OFS_ACTIVE);

	wire wr_config  = wr_i && hit_config;
	wire wr_alloc   = wr_i && hit_alloc;
	wire wr_restart = wr_i && hit_restart && wr_data_i[`SISR_RESTART_BIT];

	// Staged settings
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			alloc_mode_stg_q <= 1'b0;
			ctrl_mode_stg_q  <= `SISR_MODE_RST;
		end else if (wr_config) begin
			alloc_mode_stg_q <= wr_data_i[`SISR_CFG_ALLOC_BIT];
			ctrl_mode_stg_q  <= wr_data_i[`SISR_CFG_MODE_MSB:`SISR_CFG_MODE_LSB];
		end
	end

	// Top nibble has no slot behind it and is dropped on write
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			alloc_stg_q <= `SISR_ALLOC_RST;
		end else if (wr_alloc) begin
			alloc_stg_q <= {4'h0, wr_data_i[27:0]};
		end
	end

	// Live settings change only at reset or a soft restart, never mid-run
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			allocation_mode_q     <= 1'b0;                  // [RL14]
			control_mode_select_q <= `SISR_MODE_RST;
			alloc_act_q           <= `SISR_ALLOC_RST;       // [RL8] [RL17]
		end else if (restart_q) begin
			allocation_mode_q     <= alloc_mode_stg_q;      // [RL20]
			control_mode_select_q <= ctrl_mode_stg_q;       // [RL20]
			alloc_act_q           <= alloc_stg_q;           // [RL20]
		end
	end

	// One cycle delay keeps the staged write and the copy on separate edges
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			restart_q <= 1'b0;
		end else begin
			restart_q <= wr_restart;
		end
	end

	// Input synchronisers
	// Preloaded inactive so reset never shows a false active line
	sisr_pins_t pins_sync;

	sisr_sync #(
		.WIDTH (`SISR_NUM_PINS)
	) u_sync (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.async_i    (io_connector_i),   // [RL21]
		.sync_o     (pins_sync)
	);

	// One allocator per function slot
	// All slots see all lines, so one line may feed several functions
	logic [`SISR_NUM_SLOTS-1:0] slot_act;

	genvar gi;
	generate
		for (gi = 0; gi < `SISR_NUM_SLOTS; gi++) begin : g_slot
			sisr_alloc u_alloc (
				.pins_i      (pins_sync),
				.code_i      (alloc_act_q[4*gi +: 4]),
				.user_mode_i (allocation_mode_q),       // [RL14]
				.fixed_pin_i (3'(gi)),                  // [RL1] [RL9] [RL19]
				.active_o    (slot_act[gi])
			);
		end
	endgenerate

	wire run_slot   = slot_act[`SISR_SLOT_RUN];        // [RL1]
	wire gain_slot  = slot_act[`SISR_SLOT_GAIN];
	wire fpro_slot  = slot_act[`SISR_SLOT_FWD_PRO];    // [RL8]
	wire rpro_slot  = slot_act[`SISR_SLOT_REV_PRO];    // [RL8]
	wire alarm_slot = slot_act[`SISR_SLOT_ALARM];      // [RL9]
	wire flim_slot  = slot_act[`SISR_SLOT_FWD_LIM];
	wire rlim_slot  = slot_act[`SISR_SLOT_REV_LIM];

	// Control mode classes
	// Codes above b fall in no class: line two idle, limits stay limits
	sisr_mode_e cm;
	assign cm = sisr_mode_e'(control_mode_select_q);

	wire cm_basic  = (cm == SISR_CM_SPEED) || (cm == SISR_CM_POSITION);
	wire cm_int35  = (cm >= SISR_CM_INT_SPEED) && (cm <= SISR_CM_INT_POS);
	wire cm_int36  = (cm >= SISR_CM_INT_SPEED) && (cm <= SISR_CM_INT_TRQ);
	wire cm_switch = (cm >= SISR_CM_POS_SPD) && (cm <= SISR_CM_SPD_TRQ);
	wire cm_lock   = (cm == SISR_CM_SPD_LOCK);
	wire cm_inhib  = (cm == SISR_CM_POS_INHIB);

	// Limit slots double as speed selects in internal speed modes
	wire spd_a   = cm_int36 && flim_slot;               // [RL10]
	wire spd_b   = cm_int36 && rlim_slot;               // [RL11]
	wire f_lim   = !cm_int36 && flim_slot;              // [RL10]
	wire r_lim   = !cm_int36 && rlim_slot;              // [RL11]
	wire spd_any = spd_a || spd_b;

	// Second line serves a different function per mode
	wire gain_d  = gain_slot && (cm_basic || (cm_int35 && !spd_any)); // [RL2] [RL3]
	wire rotation_dir_in_d  = gain_slot && cm_int36 && spd_any;    // [RL4]
	wire mswt_d  = gain_slot && cm_switch;              // [RL5]
	wire lock_d  = gain_slot && cm_lock;                // [RL6]
	wire inhib_d = gain_slot && cm_inhib;               // [RL7]

	// Position loop in force: switch inactive selects the first mode named
	wire pos_sw  = ((cm == SISR_CM_POS_SPD) || (cm == SISR_CM_POS_TRQ)) && !mswt_d;
	wire pos_int = (cm == SISR_CM_INT_POS) && !spd_any;
	wire pos_act = (cm == SISR_CM_POSITION) || cm_inhib || pos_sw || pos_int;

	wire pair1_d = pos_act ? positioning_done_i : speed_match_i; // [RL12]

	// Functions with a slot of their own, all registered
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			run_o             <= 1'b0;
			fwd_prohibit_in_o <= 1'b0;
			rev_prohibit_o    <= 1'b0;
			alarm_reset_o     <= 1'b0;
		end else begin
			run_o             <= run_slot;     // [RL1]
			fwd_prohibit_in_o <= fpro_slot;    // [RL8]
			rev_prohibit_o    <= rpro_slot;    // [RL8]
			alarm_reset_o     <= alarm_slot;   // [RL9]
		end
	end

	// Line-two group: at most one of these follows the slot in any mode
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			gain_reduce_in_o      <= 1'b0;
			rotation_dir_in_o     <= 1'b0;
			ctrl_mode_switch_in_o <= 1'b0;
			position_lock_in_o    <= 1'b0;
			pulse_inhibit_in_o    <= 1'b0;
		end else begin
			gain_reduce_in_o      <= gain_d;    // [RL2] [RL3]
			rotation_dir_in_o     <= rotation_dir_in_d;    // [RL4]
			ctrl_mode_switch_in_o <= mswt_d;    // [RL5]
			position_lock_in_o    <= lock_d;    // [RL6]
			pulse_inhibit_in_o    <= inhib_d;   // [RL7]
		end
	end

	// Limit slots: current limits or speed selects, never both at once
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			fwd_current_limit_in_o <= 1'b0;
			rev_current_limit_in_o <= 1'b0;
			speed_sel_a_in_o       <= 1'b0;
			speed_sel_b_in_o       <= 1'b0;
		end else begin
			fwd_current_limit_in_o <= f_lim;   // [RL10]
			rev_current_limit_in_o <= r_lim;   // [RL11]
			speed_sel_a_in_o       <= spd_a;   // [RL10]
			speed_sel_b_in_o       <= spd_b;   // [RL11]
		end
	end

	// Pair one changes meaning with the loop in force
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			out_pair1_o <= 1'b0;
		end else begin
			out_pair1_o <= pair1_d;            // [RL12]
		end
	end

	// Status pairs are only retimed, one cycle behind the core
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			out_pair2_o <= 1'b0;
			out_pair3_o <= 1'b0;
		end else begin
			out_pair2_o <= motor_rotating_i;   // [RL13]
			out_pair3_o <= servo_ready_i;      // [RL13]
		end
	end

	// Read-back views
	// Reads have no side effect, so software may poll freely
	sisr_word_t func_word;
	sisr_word_t config_word;
	sisr_word_t active_word;

	assign func_word = {19'h0_0000,
		speed_sel_b_in_o, speed_sel_a_in_o,
		rev_current_limit_in_o, fwd_current_limit_in_o,
		alarm_reset_o, rev_prohibit_o, fwd_prohibit_in_o,
		pulse_inhibit_in_o, position_lock_in_o,
		ctrl_mode_switch_in_o, rotation_dir_in_o,
		gain_reduce_in_o, run_o};

	assign config_word = {24'h00_0000, ctrl_mode_stg_q, 3'b000, alloc_mode_stg_q};
	assign active_word = {24'h00_0000, control_mode_select_q, 3'b000, allocation_mode_q};

	wire sisr_word_t rd_mux =
		hit_config ? config_word :
		hit_alloc  ? alloc_stg_q :
		hit_func   ? func_word :
		hit_pins   ? {25'h000_0000, pins_sync} :
		hit_active ? active_word :
		32'h0000_0000;

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			rd_data_q <= 32'h0000_0000;
		end else begin
			rd_data_q <= rd_i ? rd_mux : 32'h0000_0000;
		end
	end

	assign rd_data_o = rd_data_q;

endmodule : sisr_router

`default_nettype wire

// ==== design/sisr_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module sisr_sync #(
	parameter int WIDTH = 7
) (
	input  wire logic             core_clk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			meta_q <= '1;
			sync_o <= '1;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule : sisr_sync

`default_nettype wire

// ==== shared/sisr_consts.svh ====
`ifndef SISR_CONSTS_SVH
`define SISR_CONSTS_SVH

// Register bus geometry
`define SISR_ADDR_W        8
`define SISR_DATA_W        32

// Register offsets (byte addresses)
`define SISR_OFS_CONFIG    8'h00
`define SISR_OFS_ALLOC     8'h04
`define SISR_OFS_RESTART   8'h08
`define SISR_OFS_FUNC      8'h0C
`define SISR_OFS_PINS      8'h10
`define SISR_OFS_ACTIVE    8'h14

// CONFIG fields
`define SISR_CFG_ALLOC_BIT 0
`define SISR_CFG_MODE_LSB  4
`define SISR_CFG_MODE_MSB  7

// RESTART field
`define SISR_RESTART_BIT   0

// Reset values: fixed allocation, position control
`define SISR_CFG_RST       32'h0000_0010
`define SISR_MODE_RST      4'h1
// Nibble per slot: run 0, gain 1, fwd/rev prohibit 8, alarm 4, limits 5/6
`define SISR_ALLOC_RST     32'h0654_8810

// Allocation codes
`define SISR_CODE_ON       4'h7
`define SISR_CODE_OFF      4'h8
`define SISR_CODE_HI_BASE  4'h9

// Connector and slots
`define SISR_NUM_PINS      7
`define SISR_NUM_SLOTS     7
`define SISR_SLOT_RUN      0
`define SISR_SLOT_GAIN     1
`define SISR_SLOT_FWD_PRO  2
`define SISR_SLOT_REV_PRO  3
`define SISR_SLOT_ALARM    4
`define SISR_SLOT_FWD_LIM  5
`define SISR_SLOT_REV_LIM  6

`endif

// ==== shared/sisr_pkg.sv ====
package sisr_pkg;

	typedef logic [3:0]  sisr_code_t;
	typedef logic [6:0]  sisr_pins_t;
	typedef logic [7:0]  sisr_addr_t;
	typedef logic [31:0] sisr_word_t;

	typedef enum logic [3:0] {
		SISR_CM_SPEED      = 4'h0,
		SISR_CM_POSITION   = 4'h1,
		SISR_CM_TORQUE     = 4'h2,
		SISR_CM_INT_SPEED  = 4'h3,
		SISR_CM_INT_SPD    = 4'h4,
		SISR_CM_INT_POS    = 4'h5,
		SISR_CM_INT_TRQ    = 4'h6,
		SISR_CM_POS_SPD    = 4'h7,
		SISR_CM_POS_TRQ    = 4'h8,
		SISR_CM_SPD_TRQ    = 4'h9,
		SISR_CM_SPD_LOCK   = 4'hA,
		SISR_CM_POS_INHIB  = 4'hB
	} sisr_mode_e;

endpackage : sisr_pkg

// ==== sim/sisr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module sisr_host_model (
	input  wire logic                 core_clk_i,
	input  wire sisr_pkg::sisr_pins_t level_i,
	output sisr_pkg::sisr_pins_t      io_connector_o
);
	import sisr_pkg::*;
	// Host output stage changes the lines just after an edge, never mid-cycle
	always_ff @(posedge core_clk_i) begin
		io_connector_o <= level_i;
	end
endmodule : sisr_host_model

`default_nettype wire

// ==== sim/sisr_router_properties.sv ====
`timescale 1ns/1ps
`default_nettype none

module sisr_router_properties (
	input wire logic                 core_clk_i,
	input wire logic                 reset_i,
	input wire sisr_pkg::sisr_addr_t addr_i,
	input wire sisr_pkg::sisr_word_t wr_data_i,
	input wire logic                 wr_i,
	input wire logic                 rd_i,
	input wire sisr_pkg::sisr_word_t rd_data_o,
	input wire sisr_pkg::sisr_pins_t io_connector_i,
	input wire logic                 positioning_done_i,
	input wire logic                 motor_rotating_i,
	input wire logic                 servo_ready_i,
	input wire logic                 run_o,
	input wire logic                 gain_reduce_in_o,
	input wire logic                 fwd_prohibit_in_o,
	input wire logic                 rev_prohibit_o,
	input wire logic                 alarm_reset_o,
	input wire logic                 fwd_current_limit_in_o,
	input wire logic                 rev_current_limit_in_o,
	input wire logic                 speed_sel_a_in_o,
	input wire logic                 out_pair1_o,
	input wire logic                 out_pair2_o,
	input wire logic                 out_pair3_o
);
	import sisr_pkg::*;
	logic [1:0] cnt_q;
	logic       dflt_q;
	// Pin checks only while reset defaults are live and the pipeline is full
	wire        live_w = dflt_q && cnt_q == 2'd3;
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			cnt_q  <= 2'd0;
			dflt_q <= 1'b1;
		end else begin
			if (cnt_q != 2'd3)
				cnt_q <= cnt_q + 2'd1;
			if (wr_i && addr_i == 8'h08 && wr_data_i[0])
				dflt_q <= 1'b0;
		end
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	run_line_one_a: assert property (
		live_w |-> run_o == !$past(io_connector_i[0], 3))
		else $error("run output does not follow line one");
	gain_line_two_a: assert property (
		live_w |-> gain_reduce_in_o == !$past(io_connector_i[1], 3))
		else $error("gain reduction does not follow line two");
	alarm_line_five_a: assert property (
		live_w |-> alarm_reset_o == !$past(io_connector_i[4], 3))
		else $error("alarm reset does not follow line five");
	prohibit_off_a: assert property (
		live_w |-> !fwd_prohibit_in_o && !rev_prohibit_o)
		else $error("drive prohibit active under defaults");
	fwd_limit_map_a: assert property (
		live_w |-> fwd_current_limit_in_o == !$past(io_connector_i[5], 3))
		else $error("forward limit does not follow line six");
	rev_limit_map_a: assert property (
		live_w |-> rev_current_limit_in_o == !$past(io_connector_i[6], 3) && !speed_sel_a_in_o)
		else $error("reverse limit does not follow line seven");
	pair_one_pos_a: assert property (
		live_w |-> out_pair1_o == $past(positioning_done_i))
		else $error("pair one not showing positioning done");
	pair_status_a: assert property (
		cnt_q != 2'd0 |-> out_pair2_o == $past(motor_rotating_i) && out_pair3_o == $past(servo_ready_i))
		else $error("pair two or three wrong");
	read_idle_zero_a: assert property (!$past(rd_i) |-> rd_data_o == 32'h0000_0000)
		else $error("read data outside its cycle");
	cover property (live_w && $rose(run_o));
	cover property (!dflt_q && $rose(out_pair1_o));
	cover property (!dflt_q && $rose(fwd_prohibit_in_o));
endmodule : sisr_router_properties

`default_nettype wire

// ==== sim/sisr_router_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module sisr_router_tb;
	import sisr_pkg::*;
	logic        core_clk_i;
	logic        reset_i;
	sisr_addr_t  addr_i;
	sisr_word_t  wr_data_i;
	logic        wr_i;
	logic        rd_i;
	sisr_word_t  rd_data_o;
	sisr_pins_t  pin_req;
	sisr_pins_t  io_connector_i;
	logic [3:0]  sts = 4'h0;
	logic [12:0] fn;
	logic [2:0]  pair;
	int          err_total;
	int          comparisons;
	int          cyc = 0;

	sisr_host_model i_sisr_host_model (.core_clk_i(core_clk_i), .level_i(pin_req),
		.io_connector_o(io_connector_i));
	sisr_router i_sisr_router (.core_clk_i(core_clk_i), .reset_i(reset_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
		.io_connector_i(io_connector_i), .positioning_done_i(sts[3]), .speed_match_i(sts[2]),
		.motor_rotating_i(sts[1]), .servo_ready_i(sts[0]), .run_o(fn[0]),
		.gain_reduce_in_o(fn[1]), .rotation_dir_in_o(fn[2]), .ctrl_mode_switch_in_o(fn[3]),
		.position_lock_in_o(fn[4]), .pulse_inhibit_in_o(fn[5]), .fwd_prohibit_in_o(fn[6]),
		.rev_prohibit_o(fn[7]), .alarm_reset_o(fn[8]), .fwd_current_limit_in_o(fn[9]),
		.rev_current_limit_in_o(fn[10]), .speed_sel_a_in_o(fn[11]), .speed_sel_b_in_o(fn[12]),
		.out_pair1_o(pair[0]), .out_pair2_o(pair[1]), .out_pair3_o(pair[2]));

	task automatic final_report;
		$display("mismatches %0d of %0d comparisons", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// One strobe cycle; returns just after the edge where read data stands
	task automatic bus(input logic wr, input sisr_addr_t a, input sisr_word_t d);
		@(posedge core_clk_i);
		wr_i      <= wr;
		rd_i      <= !wr;
		addr_i    <= a;
		wr_data_i <= d;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		#1;
	endtask : bus

	task automatic rdc(input sisr_addr_t a, input sisr_word_t exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd_data_o, exp);
	endtask : rdc

	task automatic setup(input sisr_word_t cfg, input sisr_word_t alloc);
		bus(1'b1, 8'h00, cfg);
		bus(1'b1, 8'h04, alloc);
		bus(1'b1, 8'h08, 32'h0000_0001);
		repeat (4) @(posedge core_clk_i);
	endtask : setup

	task automatic pins(input sisr_pins_t p);
		@(posedge core_clk_i);
		pin_req <= p;
		repeat (5) @(posedge core_clk_i);
		#1;
	endtask : pins

	task automatic do_reset;
		@(posedge core_clk_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		reset_i <= 1'b0;
	endtask : do_reset

	function automatic logic [12:0] em(input logic [3:0] m, input logic [6:0] a);
		logic        sp;
		logic        s;
		logic [12:0] f;
		sp    = m >= 4'h3 && m <= 4'h6;
		s     = sp && (a[5] || a[6]);
		f     = 13'h0000;
		f[0]  = a[0];
		f[1]  = a[1] && (m <= 4'h1 || (m >= 4'h3 && m <= 4'h5 && !s));
		f[2]  = a[1] && s;
		f[3]  = a[1] && m >= 4'h7 && m <= 4'h9;
		f[4]  = a[1] && m == 4'hA;
		f[5]  = a[1] && m == 4'hB;
		f[8]  = a[4];
		f[9]  = !sp && a[5];
		f[10] = !sp && a[6];
		f[11] = sp && a[5];
		f[12] = sp && a[6];
		return f;
	endfunction : em

	task automatic t_defaults;
		rdc(8'h00, 32'h0000_0010);
		rdc(8'h04, 32'h0654_8810);
		chk(fn, 13'h0000);
		bus(1'b1, 8'h20, 32'hFFFF_FFFF);
		rdc(8'h20, 32'h0000_0000);
		bus(1'b1, 8'h04, 32'hF654_8810);
		rdc(8'h04, 32'h0654_8810);
		for (int i = 0; i < 7; i++) begin
			pins(~(7'h01 << i));
			chk(fn, em(4'h1, 7'h01 << i));
			rdc(8'h10, {25'h000_0000, ~(7'h01 << i)});
			rdc(8'h0C, {19'h0_0000, em(4'h1, 7'h01 << i)});
		end
	endtask : t_defaults

	task automatic t_user;
		setup(32'h0000_0011, 32'h0653_87B3);
		pins(7'h77);
		chk(fn, 13'h0143);
		pins(7'h7B);
		chk(fn, 13'h0040);
		bus(1'b1, 8'h00, 32'h0000_0010);
		pins(7'h77);
		chk(fn, 13'h0143);
		rdc(8'h14, 32'h0000_0011);
	endtask : t_user

	task automatic t_force;
		do_reset;
		rdc(8'h14, 32'h0000_0010);
		setup(32'h0000_0010, 32'h0658_87B7);
		pins(7'h7F);
		chk(fn, 13'h0041);
		pins(7'h6D);
		chk(fn, 13'h0043);
	endtask : t_force

	task automatic t_modes;
		logic [6:0] pat [4];
		logic       p;
		logic       s;
		logic [1:0] q;
		pat = '{7'h02, 7'h22, 7'h40, 7'h42};
		for (int m = 0; m < 12; m++) begin
			setup({24'h00_0000, m[3:0], 4'h0}, 32'h0654_8810);
			for (int k = 0; k < 4; k++) begin
				pins(~pat[k]);
				chk(fn, em(m[3:0], pat[k]));
				s = m >= 3 && m <= 6 && (pat[k][5] || pat[k][6]);
				p = m == 1 || m == 11 || (m == 5 && !s) || ((m == 7 || m == 8) && !pat[k][1]);
				p = p ? sts[3] : sts[2];
				q = sts[1:0];
				@(posedge core_clk_i);
				#1;
				chk(pair[0], p);
				chk(pair[2:1], {q[0], q[1]});
			end
		end
	endtask : t_modes

	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end

	// Status lines toggle at varied rates so the output pairs show any slip
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		sts <= cyc[4:1];
		if (cyc == 20000) begin
			err_total++;
			final_report;
		end
	end

	initial begin
		reset_i = 1'b1;
		addr_i = 8'h00;
		wr_data_i = 32'h0000_0000;
		wr_i = 1'b0;
		rd_i = 1'b0;
		pin_req = 7'h7F;
		err_total = 0;
		comparisons = 0;
		repeat (3) @(posedge core_clk_i);
		reset_i <= 1'b0;
		t_defaults;
		t_user;
		t_force;
		t_modes;
		do_reset;
		rdc(8'h00, 32'h0000_0010);
		final_report;
	end
endmodule : sisr_router_tb

bind sisr_router sisr_router_properties i_sisr_router_properties (.*);

`default_nettype wire
